// ### src/slbc_pkg.sv
// Contract
// - After power-up both LEDs stay dark for about four seconds.
// - Boot stage two blinks the access-point LED red for about forty seconds.
// - Stage three blinks access-point LED green ten seconds, dark if disabled.
// - Stage four starts the link LED blinking blue, off if link disabled.
// - In operation access-point LED blinks red when disabled, green when enabled.
// - Link LED off when disabled, blinking when enabled, solid when connected.
// - A cleared LED enable setting turns both LEDs off.
// - A short press inverts both radio enables together.
// - Long press lights both LEDs two seconds, then fast green blink.
// - Long press restores all network settings to defaults.
// - After factory reset radios stay off until the next power cycle.
package slbc_pkg;
	localparam int CLK_HZ          = 100_000_000;
	localparam int BOOT1_MS        = 4000;
	localparam int BOOT2_MS        = 40000;
	localparam int BOOT3_MS        = 10000;
	localparam int LONG_MS         = 4000;
	localparam int SOLID_MS        = 2000;
	localparam int DEBOUNCE_MS     = 5;
	localparam int BLINK_MS        = 500;
	localparam int FAST_MS         = 100;
	localparam int MS_CYC          = CLK_HZ / 1000;
	localparam int DEBOUNCE_CYC    = DEBOUNCE_MS * MS_CYC;
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STAT   = 8'h04;
	localparam logic [7:0] ADDR_IRQ    = 8'h08;
	localparam logic [7:0] ADDR_MASK   = 8'h0C;
	localparam logic [7:0] ADDR_NET    = 8'h10;
	localparam int CTRL_LED_EN     = 0;
	localparam int CTRL_PHONE_CONN = 1;
	localparam int CTRL_AP_BOOT    = 2;
	localparam int CTRL_LINK_BOOT  = 3;
	localparam logic [31:0] CTRL_RST   = 32'h0000000D;
	localparam int IRQ_SHORT       = 0;
	localparam int IRQ_LONG        = 1;
	localparam int IRQ_BOOT_DONE   = 2;
	localparam int NET_DHCP        = 0;
	localparam int NET_AP          = 1;
	localparam int NET_PW_SET      = 2;
	localparam int NET_LAN_CON     = 3;
	localparam int NET_CLOUD_CON   = 4;
	localparam int NET_PIN_DEF     = 5;
	localparam logic [31:0] NET_DEF    = 32'h0000003B;
	localparam logic [1:0] RESP_OK     = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [2:0] {
		SLBC_BOOT1, SLBC_BOOT2, SLBC_BOOT3, SLBC_RUN, SLBC_LP_SOLID, SLBC_LP_CUE
	} slbc_state_e;
endpackage

// ### src/slbc_debounce.sv
`timescale 1ns/100ps
module slbc_debounce
	import slbc_pkg::*;
#(
	parameter int DEB_CYCLES = DEBOUNCE_CYC
)
(
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic raw,
	output logic      level
);
	logic        s1_r;
	logic        s2_r;
	logic [19:0] cnt_r;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
		end else begin
			s1_r <= raw;
			s2_r <= s1_r;
		end
	end

	// Level only follows after staying stable for the debounce time
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r <= 20'h00000;
			level <= 1'b0;
		end else if (s2_r == level) begin
			cnt_r <= 20'h00000;
		end else if (cnt_r == 20'(DEB_CYCLES - 1)) begin
			cnt_r <= 20'h00000;
			level <= s2_r;
		end else begin
			cnt_r <= cnt_r + 20'h00001;
		end
	end
endmodule

// ### src/slbc_top.sv
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
module slbc_top
	import slbc_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYC
)
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        button_n,
	output logic             ap_led_red,
	output logic             ap_led_green,
	output logic             link_led_blue,
	output logic             ap_enable,
	output logic             link_enable,
	output logic             irq,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	function automatic logic wsel(input logic [7:0] a, input logic [7:0] b);
		return a == b;
	endfunction

	slbc_state_e state_r;
	slbc_state_e state_nxt;
	logic [31:0] ctrl_r;
	logic [31:0] net_r;
	logic [2:0]  irq_st_r;
	logic [2:0]  irq_mask_r;
	logic        ap_en_r;
	logic        link_en_r;
	logic        radio_lock_r;
	logic [16:0] ms_div_r;
	logic [15:0] ms_cnt_r;
	logic [15:0] press_ms_r;
	logic        press_long_r;
	logic        btn_prev_r;
	logic        btn;
	logic        ms_tick;
	logic        aw_have_r;
	logic        w_have_r;
	logic [7:0]  aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0]  w_strb_r;

	// Debounce time follows the millisecond scale of the sequencer
	slbc_debounce #(
		.DEB_CYCLES (DEBOUNCE_MS * MS_CYCLES)
	) slbc_debounce_i (
		.clk    (clk),
		.arst_n (arst_n),
		.raw    (~button_n),
		.level  (btn)
	);

	assign ms_tick = ms_div_r == 17'(MS_CYCLES - 1);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			ms_div_r <= 17'h00000;
		else
			ms_div_r <= ms_tick ? 17'h00000 : ms_div_r + 17'h00001;
	end

	// Button press classification
	wire press_rise  = btn & ~btn_prev_r;
	wire press_fall  = ~btn & btn_prev_r;
	wire long_hit    = btn & ~press_long_r & ms_tick & (press_ms_r == 16'(LONG_MS - 1));
	wire short_evt   = press_fall & ~press_long_r & (state_r == SLBC_RUN);
	wire long_evt    = long_hit & (state_r == SLBC_RUN);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			btn_prev_r   <= 1'b0;
			press_ms_r   <= 16'h0000;
			press_long_r <= 1'b0;
		end else begin
			btn_prev_r <= btn;
			if (press_rise) begin
				press_ms_r   <= 16'h0000;
				press_long_r <= 1'b0;
			end else if (long_hit) begin
				press_long_r <= 1'b1;
			end else if (btn && ms_tick) begin
				press_ms_r <= press_ms_r + 16'h0001;
			end
		end
	end

	// Boot and long-press sequencer
	wire stage_end = ms_tick & (
		(state_r == SLBC_BOOT1 && ms_cnt_r == 16'(BOOT1_MS - 1)) ||
		(state_r == SLBC_BOOT2 && ms_cnt_r == 16'(BOOT2_MS - 1)) ||
		(state_r == SLBC_BOOT3 && ms_cnt_r == 16'(BOOT3_MS - 1)) ||
		(state_r == SLBC_LP_SOLID && ms_cnt_r == 16'(SOLID_MS - 1)));

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			SLBC_BOOT1:    if (stage_end) state_nxt = SLBC_BOOT2;
			SLBC_BOOT2:    if (stage_end) state_nxt = SLBC_BOOT3;
			SLBC_BOOT3:    if (stage_end) state_nxt = SLBC_RUN;
			SLBC_RUN:      if (long_evt) state_nxt = SLBC_LP_SOLID;
			SLBC_LP_SOLID: if (stage_end) state_nxt = SLBC_LP_CUE;
			SLBC_LP_CUE:   if (!btn) state_nxt = SLBC_RUN;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r  <= SLBC_BOOT1;
			ms_cnt_r <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			if (state_nxt != state_r)
				ms_cnt_r <= 16'h0000;
			else if (ms_tick)
				ms_cnt_r <= ms_cnt_r + 16'h0001;
		end
	end

	// Radio enables
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ap_en_r      <= 1'b0;
			link_en_r    <= 1'b0;
			radio_lock_r <= 1'b0;
		end else if (state_r == SLBC_BOOT1 && ms_cnt_r == 16'h0000 && ms_tick) begin
			ap_en_r   <= ctrl_r[CTRL_AP_BOOT];
			link_en_r <= ctrl_r[CTRL_LINK_BOOT];
		end else if (long_evt) begin
			ap_en_r      <= 1'b0;
			link_en_r    <= 1'b0;
			radio_lock_r <= 1'b1;
		end else if (short_evt && !radio_lock_r) begin
			ap_en_r   <= ~ap_en_r;
			link_en_r <= ~link_en_r;
		end
	end

	assign ap_enable   = ap_en_r;
	assign link_enable = link_en_r;

	// LED drive
	logic [15:0] blink_ms_r;
	logic        blink_r;
	logic        fast_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			blink_ms_r <= 16'h0000;
			blink_r    <= 1'b0;
			fast_r     <= 1'b0;
		end else if (ms_tick) begin
			blink_ms_r <= (blink_ms_r == 16'(BLINK_MS - 1)) ? 16'h0000 : blink_ms_r + 16'h0001;
			if (blink_ms_r == 16'(BLINK_MS - 1))
				blink_r <= ~blink_r;
			if (blink_ms_r % 16'(FAST_MS) == 16'h0000)
				fast_r <= ~fast_r;
		end
	end

	wire leds_on = ctrl_r[CTRL_LED_EN];
	wire conn    = ctrl_r[CTRL_PHONE_CONN];
	logic red_c;
	logic green_c;
	logic blue_c;
	always_comb begin
		red_c   = 1'b0;
		green_c = 1'b0;
		blue_c  = 1'b0;
		unique case (state_r)
			SLBC_BOOT1:    ;
			SLBC_BOOT2:    red_c = blink_r;
			SLBC_BOOT3:    green_c = blink_r & ap_en_r;
			SLBC_RUN: begin
				red_c   = blink_r & ~ap_en_r;
				green_c = blink_r & ap_en_r;
				blue_c  = link_en_r & (conn | blink_r);
			end
			SLBC_LP_SOLID: begin
				green_c = 1'b1;
				blue_c  = 1'b1;
			end
			SLBC_LP_CUE:   green_c = fast_r;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ap_led_red    <= 1'b0;
			ap_led_green  <= 1'b0;
			link_led_blue <= 1'b0;
		end else begin
			ap_led_red    <= red_c & leds_on;
			ap_led_green  <= green_c & leds_on;
			link_led_blue <= blue_c & leds_on;
		end
	end

	// Interrupt events
	wire [2:0] irq_set = {state_r == SLBC_BOOT3 && stage_end, long_evt, short_evt};

	// AXI4-Lite write path
	wire do_write   = aw_have_r & w_have_r & ~s_axi_bvalid;
	wire wr_ctrl    = do_write & wsel(aw_addr_r, ADDR_CTRL);
	wire wr_irq     = do_write & wsel(aw_addr_r, ADDR_IRQ);
	wire wr_mask    = do_write & wsel(aw_addr_r, ADDR_MASK);
	wire wr_net     = do_write & wsel(aw_addr_r, ADDR_NET);
	wire wr_ok      = wr_ctrl | wr_irq | wr_mask | wr_net | wsel(aw_addr_r, ADDR_STAT);
	wire [31:0] wm  = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

	assign s_axi_awready = ~aw_have_r;
	assign s_axi_wready  = ~w_have_r;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_have_r    <= 1'b0;
			w_have_r     <= 1'b0;
			aw_addr_r    <= 8'h00;
			w_data_r     <= 32'h00000000;
			w_strb_r     <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OK;
		end else begin
			if (s_axi_awvalid && !aw_have_r) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && !w_have_r) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_have_r    <= 1'b0;
				w_have_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? RESP_OK : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_r     <= CTRL_RST;
			irq_mask_r <= 3'h0;
			irq_st_r   <= 3'h0;
			net_r      <= NET_DEF;
		end else begin
			if (wr_ctrl)
				ctrl_r <= ((ctrl_r & ~wm) | (w_data_r & wm)) & 32'h0000000F;
			if (wr_mask)
				irq_mask_r <= (irq_mask_r & ~wm[2:0]) | (w_data_r[2:0] & wm[2:0]);
			irq_st_r <= (irq_st_r & ~(wr_irq ? w_data_r[2:0] & wm[2:0] : 3'h0)) | irq_set;
			if (long_evt)
				net_r <= NET_DEF;
			else if (wr_net)
				net_r <= ((net_r & ~wm) | (w_data_r & wm)) & 32'h0000003F;
		end
	end

	assign irq = |(irq_st_r & irq_mask_r);

	// AXI4-Lite read path
	wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
	wire [31:0] stat_v = {24'h000000, 1'b0, 3'(state_r), radio_lock_r, btn, link_en_r, ap_en_r};
	logic [31:0] rd_c;
	logic        rd_ok;
	always_comb begin
		rd_ok = 1'b1;
		rd_c  = 32'h00000000;
		if (wsel(ra, ADDR_CTRL))
			rd_c = ctrl_r;
		else if (wsel(ra, ADDR_STAT))
			rd_c = stat_v;
		else if (wsel(ra, ADDR_IRQ))
			rd_c = {29'h00000000, irq_st_r};
		else if (wsel(ra, ADDR_MASK))
			rd_c = {29'h00000000, irq_mask_r};
		else if (wsel(ra, ADDR_NET))
			rd_c = net_r;
		else
			rd_ok = 1'b0;
	end

	assign s_axi_arready = ~s_axi_rvalid;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= RESP_OK;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_c;
			s_axi_rresp  <= rd_ok ? RESP_OK : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// ### tb/slbc_monitor.sv
`timescale 1ns/100ps
module slbc_monitor
	import slbc_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYC
)
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ap_led_red,
	input wire logic ap_led_green,
	input wire logic link_led_blue,
	input wire logic ap_enable,
	input wire logic link_enable,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid
);
	// Margin covers the first ms tick and the LED lag
	localparam int M  = 2 * MS_CYCLES + 4;
	localparam int T1 = BOOT1_MS * MS_CYCLES;
	localparam int T2 = T1 + BOOT2_MS * MS_CYCLES;
	localparam int T3 = T2 + BOOT3_MS * MS_CYCLES;
	int   cyc_r;
	int   cyc_nxt;
	logic run;
	assign run     = cyc_r > T3 + M;
	assign cyc_nxt = run ? cyc_r : cyc_r + 1;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cyc_r <= 0;
		end else begin
			cyc_r <= cyc_nxt;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	dark_boot_a: assert property (cyc_r < T1 - M |-> !ap_led_red && !ap_led_green && !link_led_blue)
		else $error("LED lit in first stage");
	red_stage_a: assert property (cyc_r > T1 + M && cyc_r < T2 - M |-> !ap_led_green && !link_led_blue)
		else $error("wrong LED in second stage");
	green_stage_a: assert property (cyc_r > T2 + M && cyc_r < T3 - M |-> !ap_led_red && !link_led_blue)
		else $error("wrong LED in third stage");
	radio_pair_a: assert property (run && $changed(ap_enable) |-> $changed(link_enable))
		else $error("radios toggled apart");
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	wr_busy_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer held after taken");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
		else $error("read answer late");
	rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
endmodule
bind slbc_top slbc_monitor #(.MS_CYCLES(MS_CYCLES)) slbc_monitor_i (
	.clk           (clk),
	.arst_n        (arst_n),
	.ap_led_red    (ap_led_red),
	.ap_led_green  (ap_led_green),
	.link_led_blue (link_led_blue),
	.ap_enable     (ap_enable),
	.link_enable   (link_enable),
	.s_axi_awvalid (s_axi_awvalid),
	.s_axi_awready (s_axi_awready),
	.s_axi_wvalid  (s_axi_wvalid),
	.s_axi_wready  (s_axi_wready),
	.s_axi_bvalid  (s_axi_bvalid),
	.s_axi_bready  (s_axi_bready),
	.s_axi_arvalid (s_axi_arvalid),
	.s_axi_arready (s_axi_arready),
	.s_axi_rvalid  (s_axi_rvalid)
);

// ### tb/slbc_operator.sv
`timescale 1ns/100ps
module slbc_operator (
	input  wire logic clk,
	input  wire logic press,
	output logic      button_n
);
	logic last_r   = 1'b0;
	int   bounce_r = 0;
	initial button_n = 1'b1;
	// Contacts chatter for a few cycles after each change of hand
	always @(posedge clk) begin
		last_r <= press;
		if (press !== last_r) begin
			bounce_r <= 7;
		end else if (bounce_r > 0) begin
			bounce_r <= bounce_r - 1;
			button_n <= bounce_r[0];
		end else begin
			button_n <= ~press;
		end
	end
endmodule

// ### tb/testbench.sv
`timescale 1ns/100ps
module testbench;
	import slbc_pkg::*;
	// One cycle per millisecond keeps the full boot sequence inside the run budget
	localparam int MS = 1;
	localparam logic [1:0] D = 2'h0;
	localparam logic [1:0] S = 2'h1;
	localparam logic [1:0] B = 2'h2;
	logic        clk = 1'b0, arst_n = 1'b0, press = 1'b0;
	logic        button_n, irq, ap_led_red, ap_led_green, link_led_blue, ap_enable, link_enable;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [5:0]  pat;
	int          errors = 0, comparisons = 0, fast;
	slbc_top #(.MS_CYCLES(MS)) slbc_top_i (.*);
	slbc_operator slbc_operator_i (.*);
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic end_sim;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic chk_led(input string what, input logic [5:0] exp);
		comparisons++;
		if (pat !== exp) begin
			errors++;
			$display("BAD %s exp %h got %h", what, exp, pat);
		end
	endtask
	task automatic hang;
		chk("wait", 32'h1, 32'h0);
		end_sim;
	endtask
	task automatic ms(input int n);
		repeat (n * MS) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(negedge clk);
			ta   = s_axi_awvalid & s_axi_awready;
			tw   = s_axi_wvalid & s_axi_wready;
			tb   = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) return;
		end
		hang;
	endtask
	task automatic rd(input logic [7:0] a);
		logic ta, tr;
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(negedge clk);
			ta   = s_axi_arvalid & s_axi_arready;
			tr   = s_axi_rvalid;
			rdat = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge clk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) return;
		end
		hang;
	endtask
	task automatic look(input int n);
		int lit[3];
		int rise;
		logic [2:0] now, was;
		lit  = '{0, 0, 0};
		rise = 0;
		was  = 3'h0;
		repeat (n * MS) begin
			@(negedge clk);
			now = {ap_led_red, ap_led_green, link_led_blue};
			for (int k = 0; k < 3; k++) lit[k] += int'(now[k] === 1'b1);
			rise += int'(now[1] & ~was[1]);
			was = now;
		end
		for (int k = 0; k < 3; k++) pat[2*k +: 2] = lit[k] == 0 ? D : lit[k] == n * MS ? S : B;
		fast = rise;
		@(posedge clk);
	endtask
	task automatic t_regs;
		rd(ADDR_CTRL);
		chk("ctrl", CTRL_RST, rdat);
		rd(ADDR_NET);
		chk("net", NET_DEF, rdat);
		rd(ADDR_MASK);
		chk("mask", 32'h0, rdat);
		rd(8'h20);
		chk("rd resp", 32'(RESP_SLVERR), 32'(resp));
		chk("rd data", 32'h0, rdat);
		wr(8'h24, 32'hFFFFFFFF);
		chk("wr resp", 32'(RESP_SLVERR), 32'(resp));
		$display("test regs done");
	endtask
	task automatic t_boot;
		look(3500);
		chk_led("stage1", {D, D, D});
		ms(2500);
		look(2000);
		chk_led("stage2", {B, D, D});
		rd(ADDR_STAT);
		chk("state", 32'h1, 32'(rdat[6:4]));
		ms(37000);
		look(2000);
		chk_led("stage3", {D, B, D});
		ms(8000);
		look(2000);
		chk_led("run", {D, B, B});
		$display("test boot done");
	endtask
	task automatic t_irq;
		rd(ADDR_IRQ);
		chk("irq stat", 32'h4, rdat);
		chk("irq masked", 32'h0, 32'(irq));
		wr(ADDR_MASK, 32'h7);
		chk("irq on", 32'h1, 32'(irq));
		wr(ADDR_IRQ, 32'h4);
		chk("irq off", 32'h0, 32'(irq));
		$display("test irq done");
	endtask
	task automatic t_ctrl;
		wr(ADDR_CTRL, CTRL_RST | 32'h2);
		look(2000);
		chk_led("phone", {D, B, S});
		wr(ADDR_CTRL, CTRL_RST & ~32'h1);
		look(2000);
		chk_led("leds off", {D, D, D});
		wr(ADDR_CTRL, CTRL_RST);
		$display("test ctrl done");
	endtask
	task automatic t_short;
		press <= 1'b1;
		ms(1000);
		press <= 1'b0;
		ms(500);
		chk("ap en", 32'h0, 32'(ap_enable));
		chk("link en", 32'h0, 32'(link_enable));
		look(2000);
		chk_led("radios off", {B, D, D});
		rd(ADDR_IRQ);
		chk("short flag", 32'h1, rdat);
		wr(ADDR_IRQ, 32'h1);
		$display("test short done");
	endtask
	task automatic t_long;
		wr(ADDR_NET, 32'h0);
		press <= 1'b1;
		ms(4500);
		look(1000);
		chk("blue solid", 32'(S), 32'(pat[1:0]));
		chk("ap solid", 32'h1, 32'(pat[5:4] == S || pat[3:2] == S));
		ms(800);
		look(1000);
		chk("fast green", 32'h1, 32'(fast > 3 && pat[3:2] == B));
		press <= 1'b0;
		ms(500);
		rd(ADDR_NET);
		chk("net", NET_DEF, rdat);
		chk("radios", 32'h0, 32'({ap_enable, link_enable}));
		rd(ADDR_IRQ);
		chk("long flag", 32'h2, rdat);
		$display("test long done");
	endtask
	task automatic t_power;
		arst_n <= 1'b0;
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		ms(2);
		chk("radios back", 32'h3, 32'({ap_enable, link_enable}));
		$display("test power done");
	endtask
	initial begin
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		t_regs;
		t_boot;
		t_irq;
		t_ctrl;
		t_short;
		t_long;
		t_power;
		end_sim;
	end
endmodule
